// ===== core/adcc_pkg.sv
// shared constants and types of the delta-sigma conversion control
// assumes a single 100 MHz device clock for all logic
package adcc_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 100000000;
	localparam int SAMPLE_HZ = 192000;
	localparam int NOM_BITS = 12;
	// modulator bits per decimated sample at the nominal rate
	localparam logic [15:0] NOM_RATIO = 16'(CLK_HZ / SAMPLE_HZ);
	// samples since a filter clear before a result is trusted
	localparam logic [2:0] SETTLE_CNT = 3'h4;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int RATIO_W = 16;
	localparam int SMP_W = 18;
	localparam int AVG_W = 8;
	localparam int RES_W = 26;

	// ----------------------------------------------------------------
	// operating modes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_CONT = 2'h1;
	localparam logic [1:0] MODE_FAST = 2'h2;
	localparam logic [1:0] MODE_AVG = 2'h3;

	// ----------------------------------------------------------------
	// sequencer states and reset values
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RESET = 4'h2,
		ST_CONV = 4'h4,
		ST_HOLD = 4'h8
	} adcc_state_t;
	localparam adcc_state_t ST_RST_VAL = ST_IDLE;
	localparam logic [RES_W-1:0] RESULT_RST_VAL = 26'h0000000;

endpackage

// ===== core/adcc_decim.sv
// decimator: turns the modulator bit stream into parallel sample words
// assumes one modulator bit per enabled clock, already synchronised
`timescale 1ns/1ps
module adcc_decim import adcc_pkg::*; (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic clr,
	input wire logic bit_in,
	input wire logic [RATIO_W-1:0] ratio,
	output logic smp_ok,
	output logic [SMP_W-1:0] smp_word
);

	typedef struct packed {
		logic [RATIO_W-1:0] cnt;
		logic [RATIO_W-1:0] acc;
		logic [2:0][RATIO_W-1:0] hist;
		logic [2:0] nsmp;
		logic [SMP_W-1:0] word;
		logic ok;
	} adcc_decim_t;

	adcc_decim_t s_r;
	adcc_decim_t s_nxt;
	logic [RATIO_W-1:0] acc_in;
	logic [SMP_W-1:0] sum;

	// zero selects the nominal ratio
	function automatic logic [RATIO_W-1:0] adcc_last(
		input logic [RATIO_W-1:0] r
	);
		logic [RATIO_W-1:0] eff;
		eff = (r == 16'h0000) ? NOM_RATIO : r;
		return eff - 16'h0001;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.ok = 1'b0;
		acc_in = s_r.acc + RATIO_W'(bit_in);
		sum = SMP_W'(acc_in);
		if (clr) begin
			s_nxt.cnt = '0;
			s_nxt.acc = '0;
			s_nxt.hist = '0;
			s_nxt.nsmp = 3'h0;
		end else if (s_r.cnt >= adcc_last(ratio)) begin
			// sinc pipeline: each word spans the last four partial sums
			for (int i = 0; i < 3; i++) begin
				sum = sum + SMP_W'(s_r.hist[i]);
			end
			s_nxt.hist = {s_r.hist[1:0], acc_in};
			s_nxt.word = sum;
			s_nxt.cnt = '0;
			s_nxt.acc = '0;
			if (s_r.nsmp != SETTLE_CNT) begin
				s_nxt.nsmp = s_r.nsmp + 3'h1;
			end
			s_nxt.ok = (s_r.nsmp >= SETTLE_CNT - 3'h1);
		end else begin
			s_nxt.cnt = s_r.cnt + 16'h0001;
			s_nxt.acc = acc_in;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign smp_ok = s_r.ok;
	assign smp_word = s_r.word;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	settled_word_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		smp_ok |-> s_r.nsmp == SETTLE_CNT)
		else $error("sample word flagged before four samples");
	clear_blocks_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(ce && clr) |=> !smp_ok && s_r.nsmp == 3'h0)
		else $error("filter clear did not discard history");

endmodule

// ===== core/adcc_ctrl.sv
// conversion sequencer of the delta-sigma converter
// assumes software strobes are one-cycle pulses on the clock; the trigger
// pin and the modulator bit come from outside and are synchronised here
`timescale 1ns/1ps

module adcc_ctrl import adcc_pkg::*; (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [1:0] mode,
	input wire logic start_bit,
	input wire logic stop,
	input wire logic soc_in,
	input wire logic mod_bit,
	input wire logic mux_change,
	input wire logic [RATIO_W-1:0] dec_ratio,
	input wire logic [AVG_W-1:0] avg_len,
	input wire logic result_rd,
	output logic [RES_W-1:0] result,
	output logic done,
	output logic eoc,
	output logic mod_reset,
	output logic idle
);

	typedef struct packed {
		logic soc_s1;
		logic soc_s2;
		logic soc_s3;
		logic bit_s1;
		logic bit_s2;
		adcc_state_t st;
		logic [1:0] mode_q;
		logic [AVG_W-1:0] avg_n;
		logic [RES_W-1:0] post;
		logic [RES_W-1:0] result;
		logic done;
		logic eoc;
		logic mod_rst;
		logic dclr;
		logic idle;
	} adcc_ctrl_t;

	localparam adcc_ctrl_t CTRL_RST = '{
		st: ST_RST_VAL,
		result: RESULT_RST_VAL,
		dclr: 1'b1,
		idle: 1'b1,
		default: '0
	};

	adcc_ctrl_t s_r;
	adcc_ctrl_t s_nxt;
	logic soc_rise;
	logic start_req;
	logic smp_ok;
	logic [SMP_W-1:0] smp_word;
	logic cap;
	logic [RES_W-1:0] cap_val;
	logic [RES_W-1:0] avg_sum;
	logic [AVG_W:0] avg_eff;

	// ----------------------------------------------------------------
	// decimator
	// ----------------------------------------------------------------
	// a zero ratio selects the nominal 12-bit, 192 ksps setting
	adcc_decim u_decim (
		.clock(clock),
		.reset_n(reset_n),
		.ce(ce),
		.clr(s_r.dclr),
		.bit_in(s_r.bit_s2),
		.ratio(dec_ratio),
		.smp_ok(smp_ok),
		.smp_word(smp_word)
	);

	// ----------------------------------------------------------------
	// start decode
	// ----------------------------------------------------------------
	// an idle-low trigger pin never rises, so leaving it open is harmless
	assign soc_rise = s_r.soc_s2 & ~s_r.soc_s3;
	assign start_req = start_bit | soc_rise;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		cap = 1'b0;
		cap_val = '0;
		avg_sum = s_r.post + RES_W'(smp_word);
		avg_eff = (avg_len == 8'h00) ? 9'h001 : {1'b0, avg_len};
		s_nxt.soc_s1 = soc_in;
		s_nxt.soc_s2 = s_r.soc_s1;
		s_nxt.soc_s3 = s_r.soc_s2;
		s_nxt.bit_s1 = mod_bit;
		s_nxt.bit_s2 = s_r.bit_s1;
		case (s_r.st)
			ST_IDLE: begin
				if (start_req) begin
					s_nxt.st = ST_RESET;
					s_nxt.mode_q = mode;
				end
			end
			ST_RESET: begin
				// a stop pulse landing on a fast filter reset must not be lost
				if (stop) begin
					s_nxt.st = ST_IDLE;
				end else begin
					s_nxt.st = ST_CONV;
				end
				s_nxt.avg_n = '0;
				s_nxt.post = '0;
			end
			ST_CONV: begin
				if (stop) begin
					s_nxt.st = ST_IDLE;
				end else if (smp_ok) begin
					if (s_r.mode_q == MODE_AVG) begin
						// sinc1 post-filter widens both ratio and resolution
						if ({1'b0, s_r.avg_n} + 9'h001 >= avg_eff) begin
							cap = 1'b1;
							cap_val = avg_sum;
							s_nxt.post = '0;
							s_nxt.avg_n = '0;
						end else begin
							s_nxt.post = avg_sum;
							s_nxt.avg_n = s_r.avg_n + 8'h01;
						end
					end else begin
						cap = 1'b1;
						cap_val = RES_W'(smp_word);
					end
					if (cap) begin
						case (s_r.mode_q)
							MODE_SINGLE: s_nxt.st = ST_HOLD;
							MODE_FAST: s_nxt.st = ST_RESET;
							default: s_nxt.st = ST_CONV;
						endcase
					end
				end
			end
			ST_HOLD: begin
				// new starts are ignored here until the result is taken
				if (result_rd) begin
					s_nxt.st = ST_IDLE;
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
		// only the reset state resets the modulator; the filter is also cleared outside conversion and on a mux change; averaging never returns there
		s_nxt.mod_rst = (s_nxt.st == ST_RESET);
		s_nxt.dclr = (s_nxt.st != ST_CONV) | mux_change;
		s_nxt.idle = (s_nxt.st == ST_IDLE);
		// a completion in the same cycle as a read keeps the flag set
		if (cap) begin
			s_nxt.result = cap_val;
			s_nxt.done = 1'b1;
			s_nxt.eoc = 1'b1;
		end else if (result_rd) begin
			s_nxt.done = 1'b0;
			s_nxt.eoc = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s_r <= CTRL_RST;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign result = s_r.result;
	assign done = s_r.done;
	assign eoc = s_r.eoc;
	assign mod_reset = s_r.mod_rst;
	assign idle = s_r.idle;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	start_taken_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(ce && s_r.st == ST_IDLE && start_req) |=> s_r.st == ST_RESET
			&& mod_reset)
		else $error("start request in standby not taken");
	eoc_held_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(eoc && !(ce && result_rd)) |=> eoc && done)
		else $error("eoc dropped without a result read");
	eoc_on_end_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(ce && cap) |=> eoc && result == $past(cap_val))
		else $error("conversion end did not raise eoc with result");
	single_back_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(ce && s_r.st == ST_HOLD && result_rd) |=> idle && !eoc && !done)
		else $error("single mode did not return to standby");
	start_ignored_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(ce && s_r.st == ST_HOLD && !result_rd) |=> s_r.st == ST_HOLD)
		else $error("start accepted before standby");
	cont_runs_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(ce && s_r.st == ST_CONV && s_r.mode_q == MODE_CONT && !stop)
			|=> s_r.st == ST_CONV && !mod_reset)
		else $error("continuous mode interrupted without stop");
	stop_ends_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(ce && stop && (s_r.st == ST_CONV || s_r.st == ST_RESET))
			|=> idle)
		else $error("stop did not return the channel to standby");
	fast_restart_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(ce && cap && s_r.mode_q == MODE_FAST) |=> mod_reset ##1
			(s_r.st == ST_CONV || !$past(ce) || $past(stop)))
		else $error("fast filter did not reset and restart");
	avg_no_reset_a: assert property (
		@(posedge clock) disable iff (!reset_n)
		(ce && s_r.st == ST_CONV && s_r.mode_q == MODE_AVG && !stop)
			|=> !mod_reset && s_r.st == ST_CONV)
		else $error("modulator reset during averaging");

endmodule

// ===== test/adcc_reader.sv
// cpu/dma reader model: answers eoc with a one-cycle result_rd pulse
// assumes the conversion control runs on the same clock
`timescale 1ns/1ps
module adcc_reader import adcc_pkg::*; (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic en,
	input wire logic [3:0] lag,
	input wire logic eoc,
	input wire logic [RES_W-1:0] result,
	output logic result_rd,
	output logic [RES_W-1:0] got,
	output int reads
);
	int wait_r;
	// one read per completion; the pulse drops before eoc is looked at again
	always @(posedge clock) begin
		if (!reset_n) begin
			result_rd <= 1'b0;
			wait_r <= 0;
			reads <= 0;
		end else if (en && eoc && !result_rd) begin
			if (wait_r == int'(lag)) begin
				result_rd <= 1'b1;
				got <= result;
				reads <= reads + 1;
				wait_r <= 0;
			end else begin
				wait_r <= wait_r + 1;
			end
		end else begin
			result_rd <= 1'b0;
		end
	end
endmodule

// ===== test/delta_sigma_adc_conversion_control_test.sv
// self-checking bench of the conversion sequencer with a reader model
// assumes the modulator stream is held at one, so each word is 4*ratio
`timescale 1ns/1ps
module delta_sigma_adc_conversion_control_test import adcc_pkg::*;;
	logic clock = 0, reset_n = 0, start_bit = 0, stop = 0, soc_in = 0;
	logic mux_change = 0, rd_en = 0, result_rd, done, eoc, mod_reset, idle;
	logic ce = 1;
	logic [1:0] mode = MODE_SINGLE;
	logic [RATIO_W-1:0] dec_ratio = 16'h0004;
	logic [AVG_W-1:0] avg_len = 8'h02;
	logic [RES_W-1:0] result, got;
	int reads, resets = 0, failures = 0, checks_done = 0, lat, n0, r0;

	adcc_ctrl dut (.clock(clock), .reset_n(reset_n), .ce(ce),
		.mode(mode), .start_bit(start_bit), .stop(stop), .soc_in(soc_in),
		.mod_bit(1'b1), .mux_change(mux_change), .dec_ratio(dec_ratio),
		.avg_len(avg_len), .result_rd(result_rd), .result(result),
		.done(done), .eoc(eoc), .mod_reset(mod_reset), .idle(idle));
	adcc_reader rdr (.clock(clock), .reset_n(reset_n), .en(rd_en),
		.lag(4'h1), .eoc(eoc), .result(result), .result_rd(result_rd),
		.got(got), .reads(reads));

	initial forever #5 clock = ~clock;
	always @(posedge clock) if (mod_reset === 1'b1) resets <= resets + 1;

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic step(int n);
		repeat (n) begin
			@(posedge clock);
			#1;
		end
	endtask
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic go(logic taken);
		start_bit = 1'b1;
		step(1);
		start_bit = 1'b0;
		chk("mod_reset", mod_reset, taken);
		chk("idle", idle, 1'b0);
	endtask
	task automatic wait_eoc(int lim, output int n);
		n = 0;
		while (eoc !== 1'b1 && n < lim) begin
			step(1);
			n++;
		end
		chk("eoc_seen", eoc, 1'b1);
	endtask
	task automatic halt();
		stop = 1'b1;
		step(1);
		stop = 1'b0;
		step(4);
		chk("idle_after_stop", idle, 1'b1);
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_single();
		rd_en = 0;
		mode = MODE_SINGLE;
		go(1'b1);
		wait_eoc(400, lat);
		chk("result", 32'(result), 32'(4 * dec_ratio));
		chk("done", done, 1'b1);
		step(6);
		chk("eoc_held", eoc, 1'b1);
		go(1'b0);
		rd_en = 1;
		step(5);
		chk("eoc_clr", eoc, 1'b0);
		chk("idle_back", idle, 1'b1);
		$display("single done");
	endtask
	task automatic t_trig();
		n0 = reads;
		soc_in = 1'b1;
		wait_eoc(400, lat);
		step(6);
		soc_in = 1'b0;
		chk("trig_reads", reads - n0, 1);
		chk("trig_word", 32'(got), 32'(4 * dec_ratio));
		$display("trigger done");
	endtask
	task automatic t_mux();
		int hits = 0;
		rd_en = 0;
		go(1'b1);
		// lands between the third and the fourth word of the conversion
		step(3 * dec_ratio + 2);
		mux_change = 1'b1;
		step(1);
		mux_change = 1'b0;
		repeat (12) begin
			step(1);
			if (eoc !== 1'b0) hits++;
		end
		chk("mux_settle", hits, 0);
		wait_eoc(400, n0);
		chk("mux_word", 32'(result), 32'(4 * dec_ratio));
		rd_en = 1;
		step(5);
		$display("mux done");
	endtask
	task automatic t_run(logic [1:0] m);
		mode = m;
		n0 = reads;
		r0 = resets;
		go(1'b1);
		step(m == MODE_AVG ? 120 : 90);
		chk("run_word", 32'(got),
			32'((m == MODE_AVG ? avg_len : 1) * 4 * dec_ratio));
		chk("run_reads", 32'(reads - n0 >= 3), 1);
		if (m == MODE_FAST) chk("fast_resets", 32'(resets - r0 >= 3), 1);
		else chk("one_reset", resets - r0, 1);
		halt();
		step(4);
		$display("mode %0d done", m);
	endtask
	task automatic t_nominal();
		dec_ratio = 16'h0000;
		mode = MODE_SINGLE;
		rd_en = 0;
		go(1'b1);
		wait_eoc(3000, lat);
		chk("nominal_word", 32'(result), 32'(4 * NOM_RATIO));
		rd_en = 1;
		step(5);
		$display("nominal done");
	endtask
	task automatic t_freeze();
		ce = 1'b0;
		start_bit = 1'b1;
		step(1);
		start_bit = 1'b0;
		step(2);
		chk("frozen_idle", idle, 1'b1);
		chk("frozen_reset", mod_reset, 1'b0);
		ce = 1'b1;
		step(2);
		chk("thawed_idle", idle, 1'b1);
		$display("freeze done");
	endtask

	initial begin
		step(4);
		reset_n = 1'b1;
		t_single();
		t_trig();
		t_mux();
		t_run(MODE_CONT);
		t_run(MODE_FAST);
		t_run(MODE_AVG);
		t_freeze();
		t_nominal();
		finish_test();
	end
	// whole run takes about 2500 cycles; 20000 cycles means a hang
	initial begin
		#200000;
		failures++;
		finish_test();
	end
endmodule
